// ---- include/fpt_pkg.sv ----
// Package for the fan PWM and tachometer block: register offsets, fields,
// reset values, timing constants and the packed state of the main module.
// Assumes a 100 MHz clock and an 8-bit register port owned by the device.
package fpt_pkg;
    // Register offsets on the byte-wide register port.
    localparam logic [7:0] TACH_COUNT_LOW_ADDR  = 8'h46;
    localparam logic [7:0] TACH_COUNT_HIGH_ADDR = 8'h47;
    localparam logic [7:0] FAN_CONFIG_ADDR      = 8'h4a;
    localparam logic [7:0] SPIN_UP_CONFIG_ADDR  = 8'h4b;
    localparam logic [7:0] PWM_VALUE_ADDR       = 8'h4c;
    localparam logic [7:0] PWM_FREQUENCY_ADDR   = 8'h4d;
    localparam logic [7:0] LUT_FIRST_ADDR       = 8'h50;
    localparam logic [7:0] LUT_LAST_ADDR        = 8'h5f;
    localparam int         LUT_STEPS            = 8;

    // Field positions inside fan_config, then field widths of the other registers.
    localparam int FAN_CFG_TACH_LO   = 0;
    localparam int FAN_CFG_TACH_HI   = 1;
    localparam int FAN_CFG_CLK_SEL   = 3;
    localparam int FAN_CFG_POLARITY  = 4;
    localparam int FAN_CFG_DIRECT    = 5;
    localparam int PWM_VALUE_BITS    = 6;
    localparam int PWM_FREQ_BITS     = 5;
    localparam int SPIN_UP_BITS      = 6;

    // Reset values and the tach count limit.
    localparam logic [7:0] FAN_CONFIG_RESET     = 8'h20;
    localparam logic [7:0] SPIN_UP_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PWM_VALUE_RESET      = 8'h00;
    localparam logic [7:0] PWM_FREQUENCY_RESET  = 8'h17;
    localparam logic [15:0] TACH_COUNT_MAX      = 16'hffff;

    // Timing: rates in Hz and the cycle counts derived from them.
    localparam int CLK_HZ          = 100_000_000;
    localparam int PWM_SLOW_HZ     = 1_400;
    localparam int PWM_FAST_HZ     = 360_000;
    localparam int TACH_REF_HZ     = 90_000;
    localparam int PWM_SLOW_CYCLES = CLK_HZ / PWM_SLOW_HZ;
    localparam int PWM_FAST_CYCLES = CLK_HZ / PWM_FAST_HZ;
    localparam int TACH_REF_CYCLES = CLK_HZ / TACH_REF_HZ;

    // Complete state of the main module.
    typedef struct packed {
        logic [7:0]       fan_config;
        logic [7:0]       spin_up_config;
        logic [7:0]       pwm_value;
        logic [7:0]       pwm_frequency;
        logic [15:0][7:0] lut;
        logic [15:0]      tach_acc;
        logic [15:0]      tach_count;
        logic [1:0]       tach_sync;
        logic             tach_prev;
        logic [5:0]       pwm_cnt;
        logic             pwm_level;
        logic [7:0]       rdata;
        logic             tach_phase;
        logic             pwm_out;
        logic             pwm_oe_n;
    } fpt_state_s;
endpackage

// ---- tb/fpt_fan_ctrl_asserts.sv ----
// Checker for the fan control block: register port and open-drain output.
// Assumes strobes last one cycle and a read follows a write two cycles on.
`timescale 1ns/1ps
module fpt_fan_ctrl_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       pwm_out
);
    // One clock domain, so the clock and reset are given once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    od_low_a: assert property (pwm_out == 1'b0)
        else $error("open-drain data not low");
    unmapped_rd_a: assert property (reg_rd && reg_addr >= 8'h60 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cfg_wr_a: assert property (reg_wr && reg_addr == 8'h4a ##2 reg_rd && reg_addr == 8'h4a
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("fan config readback");
    spin_mask_a: assert property (reg_wr && reg_addr == 8'h4b ##2 reg_rd && reg_addr == 8'h4b
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'h3f)) else $error("spin-up readback");
    duty_mask_a: assert property (reg_wr && reg_addr == 8'h4c ##2 reg_rd && reg_addr == 8'h4c
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'h3f)) else $error("pwm value readback");
    freq_mask_a: assert property (reg_wr && reg_addr == 8'h4d ##2 reg_rd && reg_addr == 8'h4d
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1f)) else $error("frequency readback");
    lut_wr_a: assert property (reg_wr && reg_addr inside {[8'h50:8'h5f]} ##2 reg_rd
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("table readback");
endmodule

bind fpt_fan_ctrl fpt_fan_ctrl_asserts i_fpt_fan_ctrl_asserts (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_out);

// ---- tb/fpt_fan_model.sv ----
// Fan model: pull-up on the open-drain PWM pin, tach edge generator.
// Assumes clk is the block's clock; lengths are counted in its cycles.
`timescale 1ns/1ps
module fpt_fan_model #(
    parameter int HALF_NS = 66660
) (
    input  wire logic clk,
    input  wire logic pwm_out,
    input  wire logic pwm_oe_n,
    output logic      tach_in,
    output int        hi_len,
    output int        per_len,
    output int        edges
);
    wire  pin = pwm_oe_n ? 1'b1 : pwm_out; // The pull-up holds a released pin high.
    logic pin_q;
    int   hi;
    int   per;
    // Two tach pulses a revolution; free running, as a spinning fan is.
    initial begin
        {pin_q, hi, per, edges} = '0;
        tach_in = 1'b0;
        forever #(HALF_NS) tach_in = ~tach_in;
    end
    // A rising pin edge closes a period, so lengths are latched there.
    always @(posedge clk) begin
        pin_q <= pin;
        if (pin && !pin_q) begin
            {hi_len, per_len} <= {hi, per};
            edges <= edges + 1;
            {hi, per} <= {32'd1, 32'd1};
        end else begin
            hi  <= hi + int'(pin);
            per <= per + 1;
        end
    end
endmodule

// ---- tb/test_fpt_fan_ctrl.sv ----
// Bench for the fan control block: registers, PWM duty, polarity, tach.
// Assumes the fan model on the far side and the checker bound in.
`timescale 1ns/1ps
module test_fpt_fan_ctrl;
    localparam int T = 20; // Shortened slow base tick keeps periods brief.
    localparam int TACH_HALF_NS = 66660; // Half a tach period of the model fan.
    localparam int TACH_TICKS   = 4 * TACH_HALF_NS / 10 / fpt_pkg::TACH_REF_CYCLES;
    logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, remote_temp = 8'h00;
    logic [7:0] reg_rdata;
    logic       tach_in, pwm_out, pwm_oe_n;
    int         hi_len, per_len, edges, error_cnt = 0, cmp_count = 0;
    fpt_fan_ctrl #(.PWM_SLOW_CYCLES(T)) i_fpt_fan_ctrl (.clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .remote_temp, .tach_in, .pwm_out, .pwm_oe_n);
    fpt_fan_model #(.HALF_NS(TACH_HALF_NS)) i_fpt_fan_model (.clk, .pwm_out, .pwm_oe_n,
        .tach_in, .hi_len, .per_len, .edges);
    // Shared compare, register cycles and the closing report.
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (exp !== got) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask
    task automatic wrd(logic [7:0] a, logic [7:0] d, logic [7:0] exp);
        wr(a, d);
        rd(a, exp);
    endtask
    // Two whole periods pass before the latched lengths are judged.
    task automatic meas(int hi_exp, int per_exp);
        int e0;
        e0 = edges;
        for (int n = 0; edges < e0 + 3; n++) begin
            if (n == 3000) begin
                error_cnt++;
                print_verdict();
            end
            @(posedge clk);
        end
        chk("pwm_high", 16'(hi_exp), 16'(hi_len));
        chk("pwm_period", 16'(per_exp), 16'(per_len));
    endtask
    task automatic t_reset();
        rd(8'h4a, fpt_pkg::FAN_CONFIG_RESET);
        rd(8'h4b, fpt_pkg::SPIN_UP_CONFIG_RESET);
        rd(8'h4c, fpt_pkg::PWM_VALUE_RESET);
        rd(8'h4d, fpt_pkg::PWM_FREQUENCY_RESET);
        rd(8'h46, 8'h00);
        wrd(8'h70, 8'h5a, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_direct();
        wrd(8'h4a, 8'h20, 8'h20);
        wrd(8'h4b, 8'hff, 8'h3f);
        wrd(8'h4d, 8'hff, 8'h1f);
        wrd(8'h4d, 8'h03, 8'h03);
        wrd(8'h4c, 8'hc2, 8'h02);
        meas(2 * T, 6 * T);
        wrd(8'h4a, 8'h30, 8'h30);
        meas(4 * T, 6 * T);
        $display("direct duty done");
    endtask
    // A fresh reset and setup leave the table as the only duty source written.
    task automatic t_table();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pwm_oe_n", 16'h0000, 16'(pwm_oe_n));
        rst_n <= 1'b1;
        wrd(8'h4a, 8'h20, 8'h20);
        wrd(8'h4b, 8'h00, 8'h00);
        wrd(8'h4d, 8'h03, 8'h03);
        for (int i = 0; i < 8; i++) begin
            wrd(8'h50 + 8'(2 * i), 8'(16 * i + 16), 8'(16 * i + 16));
            wrd(8'h51 + 8'(2 * i), 8'(i + 1), 8'(i + 1));
        end
        @(posedge clk);
        remote_temp <= 8'h35;
        wrd(8'h4a, 8'h00, 8'h00);
        meas(3 * T, 6 * T);
        $display("table duty done");
    endtask
    // Four tach rises always hold one whole revolution closed after reset.
    task automatic t_tach();
        logic tq;
        int   r;
        int   cnt;
        int   rpm;
        real  rpm_exp;
        tq = tach_in;
        r  = 0;
        for (int n = 0; r < 4; n++) begin
            if (n == 60000) begin
                error_cnt++;
                print_verdict();
            end
            @(posedge clk);
            r += int'(tach_in && !tq);
            tq = tach_in;
        end
        repeat (5) @(posedge clk);
        rd(8'h46, 8'(TACH_TICKS));
        cnt = int'(reg_rdata);
        rd(8'h46, 8'(TACH_TICKS));
        rd(8'h47, 8'h00);
        cnt = cnt + 256 * int'(reg_rdata);
        chk("tach_count", 16'(TACH_TICKS), 16'(cnt));
        // Host speed from the count must match the model fan within 0.1%.
        rpm_exp = 60.0e9 / (4.0 * TACH_HALF_NS);
        rpm     = (cnt != 0) ? 5_400_000 / cnt : 0;
        cmp_count++;
        if (real'(rpm) < 0.999 * rpm_exp || real'(rpm) > 1.001 * rpm_exp) begin
            error_cnt++;
            $display("FAIL fan_rpm expected %0d seen %0d", int'(rpm_exp), rpm);
        end
        $display("tach count done");
    endtask
    // Free-running clock, then reset and the scenarios in order.
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_direct();
        t_table();
        t_tach();
        print_verdict();
    end
endmodule

// ---- verilog/fpt_fan_ctrl.sv ----
// Fan control block: register file, open-drain PWM output with direct or
// table-driven duty, and tachometer period measurement.
// Assumes the remote temperature arrives as a byte from logic on clk and
// the tach pin is asynchronous.
`timescale 1ns/1ps
// Operation
// - duty equals value over twice frequency setting
// - registers writable any time after setup
// - tach period counted in 90 kHz ticks
// - count split into low and high bytes
// - eight temperature/PWM pairs in 50h-5Fh
module fpt_fan_ctrl #(
    parameter int PWM_SLOW_CYCLES = fpt_pkg::PWM_SLOW_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic [7:0] remote_temp,
    input  wire logic       tach_in,
    output logic            pwm_out,
    output logic            pwm_oe_n
);
    localparam int DIV_W = 17;

    fpt_pkg::fpt_state_s st_reg;
    fpt_pkg::fpt_state_s st_next;
    logic                pwm_tick;
    logic                tach_tick;
    logic [DIV_W-1:0]    pwm_period;

    // Selected PWM base clock: bit 3 picks the fast clock.
    assign pwm_period = st_reg.fan_config[fpt_pkg::FAN_CFG_CLK_SEL]
                      ? DIV_W'(fpt_pkg::PWM_FAST_CYCLES)
                      : DIV_W'(PWM_SLOW_CYCLES);

    fpt_tick_div #(.PERIOD_W(DIV_W)) u_pwm_div (
        .clk    (clk),
        .rst_n  (rst_n),
        .period (pwm_period),
        .tick   (pwm_tick)
    );

    fpt_tick_div #(.PERIOD_W(DIV_W)) u_tach_div (
        .clk    (clk),
        .rst_n  (rst_n),
        .period (DIV_W'(fpt_pkg::TACH_REF_CYCLES)),
        .tick   (tach_tick)
    );

    // Next-state logic for the whole block.
    always_comb begin
        logic [5:0] duty;
        logic [5:0] full;
        logic       tach_edge;
        st_next   = st_reg;
        duty      = '0;
        full      = '0;
        tach_edge = 1'b0;

        // Register writes are taken at any time; setup order is the host's job.
        if (reg_wr) begin
            case (reg_addr)
                fpt_pkg::FAN_CONFIG_ADDR:     st_next.fan_config     = reg_wdata;
                fpt_pkg::SPIN_UP_CONFIG_ADDR: st_next.spin_up_config =
                    {2'b00, reg_wdata[fpt_pkg::SPIN_UP_BITS-1:0]};
                fpt_pkg::PWM_VALUE_ADDR:      st_next.pwm_value      =
                    {2'b00, reg_wdata[fpt_pkg::PWM_VALUE_BITS-1:0]};
                fpt_pkg::PWM_FREQUENCY_ADDR:  st_next.pwm_frequency  =
                    {3'b000, reg_wdata[fpt_pkg::PWM_FREQ_BITS-1:0]};
                default: begin
                    if (reg_addr >= fpt_pkg::LUT_FIRST_ADDR
                        && reg_addr <= fpt_pkg::LUT_LAST_ADDR) begin
                        st_next.lut[reg_addr[3:0]] = reg_wdata;
                    end
                end
            endcase
        end

        // Reads are registered; unmapped addresses read as zero.
        if (reg_rd) begin
            case (reg_addr)
                fpt_pkg::TACH_COUNT_LOW_ADDR:  st_next.rdata = st_reg.tach_count[7:0];
                fpt_pkg::TACH_COUNT_HIGH_ADDR: st_next.rdata = st_reg.tach_count[15:8];
                fpt_pkg::FAN_CONFIG_ADDR:      st_next.rdata = st_reg.fan_config;
                fpt_pkg::SPIN_UP_CONFIG_ADDR:  st_next.rdata = st_reg.spin_up_config;
                fpt_pkg::PWM_VALUE_ADDR:       st_next.rdata = st_reg.pwm_value;
                fpt_pkg::PWM_FREQUENCY_ADDR:   st_next.rdata = st_reg.pwm_frequency;
                default: begin
                    if (reg_addr >= fpt_pkg::LUT_FIRST_ADDR
                        && reg_addr <= fpt_pkg::LUT_LAST_ADDR) begin
                        st_next.rdata = st_reg.lut[reg_addr[3:0]];
                    end else begin
                        st_next.rdata = 8'h00;
                    end
                end
            endcase
        end

        // Duty source: direct value, or the highest table step whose
        // temperature the remote reading has reached. Steps are scanned in
        // order, so a host that lists temperatures ascending gets its curve.
        if (st_reg.fan_config[fpt_pkg::FAN_CFG_DIRECT]) begin
            duty = st_reg.pwm_value[5:0];
        end else begin
            for (int i = 0; i < fpt_pkg::LUT_STEPS; i++) begin
                if (remote_temp >= st_reg.lut[2*i]) begin
                    duty = st_reg.lut[2*i+1][5:0];
                end
            end
        end

        // Period is twice the frequency setting; a zero setting holds off.
        full = {st_reg.pwm_frequency[4:0], 1'b0};
        if (pwm_tick) begin
            if (st_reg.pwm_cnt + 6'h01 >= full) begin
                st_next.pwm_cnt = '0;
            end else begin
                st_next.pwm_cnt = st_reg.pwm_cnt + 6'h01;
            end
            st_next.pwm_level = (full != 6'h00) && (st_reg.pwm_cnt < duty);
        end

        // Open-drain pin: only ever pulls low, so the data output is held at
        // zero and the enable goes low whenever the polarity-adjusted level is
        // low. Registered so the pin never glitches.
        st_next.pwm_out  = 1'b0;
        st_next.pwm_oe_n = st_reg.pwm_level ^ st_reg.fan_config[fpt_pkg::FAN_CFG_POLARITY];

        // Tach pin passes two flip-flops before the edge detector.
        st_next.tach_sync = {st_reg.tach_sync[0], tach_in};
        st_next.tach_prev = st_reg.tach_sync[1];
        tach_edge         = st_reg.tach_sync[1] && !st_reg.tach_prev;

        // Count reference ticks over every second rising edge, which is one
        // revolution of a two-pulse fan, saturating; the visible count only
        // changes when a revolution closes; the first close after reset counts
        // only from reset. A tick on the closing edge opens the next revolution,
        // so no tick is lost.
        if (tach_edge) begin
            st_next.tach_phase = !st_reg.tach_phase;
        end
        if (tach_edge && st_reg.tach_phase) begin
            st_next.tach_count = st_reg.tach_acc;
            st_next.tach_acc   = {15'h0000, tach_tick};
        end else if (tach_tick && st_reg.tach_acc != fpt_pkg::TACH_COUNT_MAX) begin
            st_next.tach_acc = st_reg.tach_acc + 16'h0001;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg                <= '0;
            st_reg.fan_config     <= fpt_pkg::FAN_CONFIG_RESET;
            st_reg.spin_up_config <= fpt_pkg::SPIN_UP_CONFIG_RESET;
            st_reg.pwm_value      <= fpt_pkg::PWM_VALUE_RESET;
            st_reg.pwm_frequency  <= fpt_pkg::PWM_FREQUENCY_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs leave straight from the state flip-flops.
    assign reg_rdata = st_reg.rdata;
    assign pwm_out   = st_reg.pwm_out;
    assign pwm_oe_n  = st_reg.pwm_oe_n;
endmodule

// ---- verilog/fpt_tick_div.sv ----
// Divider that turns the system clock into a one-cycle enable pulse.
// Assumes one clock domain; the period is given in system clock cycles.
`timescale 1ns/1ps
module fpt_tick_div #(
    parameter int PERIOD_W = 17
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [PERIOD_W-1:0] period,
    output logic                     tick
);
    typedef struct packed {
        logic [PERIOD_W-1:0] cnt;
        logic                tick;
    } fpt_div_state_s;

    fpt_div_state_s st_reg;
    fpt_div_state_s st_next;

    // Counts down to one and reloads; a period of zero acts as one.
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt <= PERIOD_W'(1)) begin
            st_next.cnt  = period;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt  = st_reg.cnt - PERIOD_W'(1);
            st_next.tick = 1'b0;
        end
    end

    // State register; the tick leaves straight from its flip-flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule
